// >>> design/dior_top.sv
// Purpose: digital input routing, output routing and two-wire decoding
// Assumes: one 50 MHz clock, synchronous active-low reset
// Notes:   configuration arrives as plain ports, no register bus
`timescale 1ns/1ns

module dior_top
    import dior_pkg::*;
#(
    parameter int unsigned FILT_TICK = FILT_STEP_CYC
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [NUM_DI-1:0] ext_input_pin_i,
    input wire logic [NUM_BIDIR-1:0] bidir_pin_i,
    output logic [NUM_BIDIR-1:0] bidir_pin_o,
    output logic [NUM_BIDIR-1:0] bidir_pin_oe_o,
    input wire logic [NUM_BIDIR-1:0] bidir_is_out_i,
    input wire logic [FILT_W-1:0] input_filter_time_i,
    input wire dior_sink_src_s [NUM_SINKS-1:0] command_sink_selector_i,
    input wire dior_out_src_s [NUM_BIDIR-1:0] out_source_i,
    input wire logic [NUM_BIDIR-1:0] output_polarity_i,
    input wire logic [15:0] status_word_one_i,
    input wire logic [15:0] status_word_two_i,
    input wire logic [7:0] preset_macro_sel_i,
    input wire logic quick_comm_i,
    input wire logic standstill_i,
    output logic [IN_W-1:0] input_state_word_o,
    output dior_cmd_s sink_cmd_o,
    output logic motor_on_o,
    output logic braking_o,
    output logic dir_ccw_o,
    output logic setpoint_negate_o,
    output logic ramp_stop_o,
    output logic fast_ramp_stop_o,
    output logic coast_stop_o,
    output logic command_set_select_o,
    output logic mop_raise_o,
    output logic mop_lower_o,
    output logic brake_release_o
);
    // --------
    // filter step divider
    // --------
    localparam int unsigned TICK_W = $clog2(FILT_TICK + 1);

    logic [TICK_W-1:0] tick_cnt;
    logic filt_step;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            tick_cnt <= '0;
            filt_step <= 1'b0;
        end else if (tick_cnt == TICK_W'(FILT_TICK - 1)) begin
            tick_cnt <= '0;
            filt_step <= 1'b1;
        end else begin
            tick_cnt <= tick_cnt + 1'b1;
            filt_step <= 1'b0;
        end
    end

    // --------
    // input conditioning
    // --------
    logic [NUM_IN-1:0] raw_in;
    logic [NUM_IN-1:0] clean_in;

    assign raw_in = {bidir_pin_i, ext_input_pin_i};

    for (genvar g = 0; g < NUM_IN; g++) begin : g_in
        dior_debounce u_deb (
            .clk_i(clk_i),
            .rst_n_i(rst_n_i),
            .step_i(filt_step),
            .pin_i(raw_in[g]),
            .filt_steps_i(input_filter_time_i),
            .level_o(clean_in[g])
        );
    end

    // a pin set up as output reads as zero in the state word
    always_comb begin
        input_state_word_o = '0;
        input_state_word_o[NUM_DI-1:0] = clean_in[NUM_DI-1:0];
        for (int i = 0; i < NUM_BIDIR; i++) begin
            input_state_word_o[BIDIR_BIT0 + i] = clean_in[NUM_DI + i] & ~bidir_is_out_i[i];
        end
    end

    // --------
    // preset macro, taken only while quick commissioning runs
    // --------
    logic [7:0] macro;
    dior_wire_e wire_mode;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            macro <= '0;
        end else if (quick_comm_i) begin
            macro <= preset_macro_sel_i;
        end
    end

    always_comb begin
        case (macro)
            MACRO_TWO_WIRE_1: wire_mode = WM_TWO_1;
            MACRO_TWO_WIRE_2: wire_mode = WM_TWO_2;
            default: wire_mode = WM_DIRECT;
        endcase
    end

    // --------
    // command sink routing
    // --------
    function automatic logic sink_pick(input dior_sink_src_s s, input logic [IN_W-1:0] w);
        return (s.word == SRC_INPUT_WORD) ? w[s.idx] : 1'b0;
    endfunction : sink_pick

    function automatic dior_sink_src_s in_src(input logic [4:0] b);
        return '{word: SRC_INPUT_WORD, idx: b};
    endfunction : in_src

    // an explicit selection wins over the macro's default wiring
    dior_sink_src_s [NUM_SINKS-1:0] eff_sel;

    always_comb begin
        eff_sel = command_sink_selector_i;
        if (wire_mode == WM_TWO_1) begin
            if (eff_sel[SNK_RUN].word != SRC_INPUT_WORD) begin
                eff_sel[SNK_RUN] = in_src(MACRO_BIT_A);
            end
            if (eff_sel[SNK_NEGATE].word != SRC_INPUT_WORD) begin
                eff_sel[SNK_NEGATE] = in_src(MACRO_BIT_B);
            end
        end else if (wire_mode == WM_TWO_2) begin
            if (eff_sel[SNK_WIRE1].word != SRC_INPUT_WORD) begin
                eff_sel[SNK_WIRE1] = in_src(MACRO_BIT_A);
            end
            if (eff_sel[SNK_WIRE2].word != SRC_INPUT_WORD) begin
                eff_sel[SNK_WIRE2] = in_src(MACRO_BIT_B);
            end
        end
    end

    logic [NUM_SINKS-1:0] next_sink;

    always_comb begin
        for (int i = 0; i < NUM_SINKS; i++) begin
            next_sink[i] = sink_pick(eff_sel[i], input_state_word_o);
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            sink_cmd_o <= '0;
        end else begin
            sink_cmd_o <= dior_cmd_s'(next_sink);
        end
    end

    // --------
    // plain sink consumers
    // --------
    assign command_set_select_o = sink_cmd_o.cds0;
    assign mop_raise_o = sink_cmd_o.mop_up & ~sink_cmd_o.mop_down;
    assign mop_lower_o = sink_cmd_o.mop_down & ~sink_cmd_o.mop_up;
    // close has priority so a wiring slip cannot drop the load
    assign brake_release_o = sink_cmd_o.brk_rel & ~sink_cmd_o.brk_close;
    assign coast_stop_o = sink_cmd_o.coast;
    assign fast_ramp_stop_o = sink_cmd_o.fast;

    // --------
    // two-wire decoding
    // --------
    logic cw_q;
    logic ccw_q;
    logic cw_first;
    dior_dir_e dir;
    dior_dir_e next_dir;

    // first-high order taken from registered edges
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cw_q <= 1'b0;
            ccw_q <= 1'b0;
            cw_first <= 1'b1;
        end else begin
            cw_q <= sink_cmd_o.wire1;
            ccw_q <= sink_cmd_o.wire2;
            if (sink_cmd_o.wire1 && !cw_q && !ccw_q) begin
                cw_first <= 1'b1;
            end else if (sink_cmd_o.wire2 && !ccw_q && !cw_q) begin
                cw_first <= 1'b0;
            end
        end
    end

    always_comb begin
        next_dir = dir;
        case (wire_mode)
            WM_TWO_1, WM_DIRECT: begin
                if (!sink_cmd_o.run) begin
                    next_dir = DIR_STOP;
                end else if (sink_cmd_o.negate) begin
                    next_dir = DIR_CCW;
                end else begin
                    next_dir = DIR_CW;
                end
            end
            WM_TWO_2: begin
                if (!sink_cmd_o.wire1 && !sink_cmd_o.wire2) begin
                    next_dir = DIR_STOP;
                end else if (dir == DIR_CW && !sink_cmd_o.wire1) begin
                    next_dir = DIR_STOP;
                end else if (dir == DIR_CCW && !sink_cmd_o.wire2) begin
                    next_dir = DIR_STOP;
                end else if (dir == DIR_STOP && standstill_i) begin
                    if (sink_cmd_o.wire1 && sink_cmd_o.wire2) begin
                        next_dir = cw_first ? DIR_CW : DIR_CCW;
                    end else if (sink_cmd_o.wire1) begin
                        next_dir = DIR_CW;
                    end else begin
                        next_dir = DIR_CCW;
                    end
                end
            end
            default: next_dir = DIR_STOP;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            dir <= DIR_STOP;
        end else begin
            dir <= next_dir;
        end
    end

    // --------
    // on/off sequence
    // --------
    dior_mot_e mot;
    logic run_req;

    assign run_req = (dir != DIR_STOP) && !sink_cmd_o.fast;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            mot <= MOT_OFF;
        end else begin
            case (mot)
                MOT_OFF: begin
                    if (run_req && !sink_cmd_o.coast) begin
                        mot <= MOT_RUN;
                    end
                end
                MOT_RUN: begin
                    if (sink_cmd_o.coast) begin
                        mot <= MOT_OFF;
                    end else if (!run_req) begin
                        mot <= MOT_BRAKE;
                    end
                end
                MOT_BRAKE: begin
                    if (sink_cmd_o.coast || standstill_i) begin
                        mot <= MOT_OFF;
                    end
                end
                default: mot <= MOT_OFF;
            endcase
        end
    end

    // direction is held while dir is DIR_STOP so the ramp ends the same way
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            dir_ccw_o <= 1'b0;
        end else if (dir != DIR_STOP) begin
            dir_ccw_o <= (dir == DIR_CCW);
        end
    end

    assign motor_on_o = (mot != MOT_OFF);
    assign braking_o = (mot == MOT_BRAKE);
    assign ramp_stop_o = (mot == MOT_BRAKE) && !sink_cmd_o.fast;
    assign setpoint_negate_o = (wire_mode == WM_TWO_2) ? dir_ccw_o : sink_cmd_o.negate;

    // --------
    // digital outputs
    // --------
    for (genvar g = 0; g < NUM_BIDIR; g++) begin : g_out
        dior_out_sel u_out (
            .clk_i(clk_i),
            .rst_n_i(rst_n_i),
            .src_i(out_source_i[g]),
            .invert_i(output_polarity_i[g]),
            .stat_one_i(status_word_one_i),
            .stat_two_i(status_word_two_i),
            .out_o(bidir_pin_o[g])
        );
    end

    assign bidir_pin_oe_o = bidir_is_out_i;

endmodule : dior_top

// >>> common/dior_pkg.sv
// Purpose: shared constants and types for the drive I/O routing block
// Assumes: 50 MHz system clock, source codes kept in their printed form
// Notes:   sink vector order matches the field order of dior_cmd_s
package dior_pkg;

    // --------
    // timing
    // --------
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned FILT_STEP_US = 1000;
    localparam int unsigned FILT_STEP_CYC = (CLK_HZ / 1_000_000) * FILT_STEP_US;
    localparam int unsigned FILT_W = 4;

    // --------
    // pins and source codes
    // --------
    localparam int unsigned NUM_DI = 4;
    localparam int unsigned NUM_BIDIR = 2;
    localparam int unsigned NUM_IN = NUM_DI + NUM_BIDIR;
    localparam int unsigned IN_W = 32;
    localparam logic [4:0] BIDIR_BIT0 = 5'h18;
    localparam logic [9:0] SRC_INPUT_WORD = 10'h2d2;
    localparam logic [7:0] SRC_STAT_ONE = 8'h34;
    localparam logic [7:0] SRC_STAT_TWO = 8'h35;
    localparam logic [7:0] SRC_OUT_OFF = 8'h00;

    // --------
    // preset macros
    // --------
    localparam logic [7:0] MACRO_TWO_WIRE_1 = 8'h3c;
    localparam logic [7:0] MACRO_TWO_WIRE_2 = 8'h3d;
    localparam logic [4:0] MACRO_BIT_A = 5'h00;
    localparam logic [4:0] MACRO_BIT_B = 5'h01;

    // --------
    // command sinks, index = bit in the sink vector
    // --------
    localparam int unsigned NUM_SINKS = 12;
    localparam int unsigned SNK_WIRE3 = 0;
    localparam int unsigned SNK_WIRE2 = 1;
    localparam int unsigned SNK_WIRE1 = 2;
    localparam int unsigned SNK_NEGATE = 3;
    localparam int unsigned SNK_BRK_CLOSE = 4;
    localparam int unsigned SNK_BRK_REL = 5;
    localparam int unsigned SNK_MOP_DOWN = 6;
    localparam int unsigned SNK_MOP_UP = 7;
    localparam int unsigned SNK_CDS0 = 8;
    localparam int unsigned SNK_FAST = 9;
    localparam int unsigned SNK_COAST = 10;
    localparam int unsigned SNK_RUN = 11;

    typedef struct packed {
        logic run;
        logic coast;
        logic fast;
        logic cds0;
        logic mop_up;
        logic mop_down;
        logic brk_rel;
        logic brk_close;
        logic negate;
        logic wire1;
        logic wire2;
        logic wire3;
    } dior_cmd_s;

    typedef struct packed {
        logic [9:0] word;
        logic [4:0] idx;
    } dior_sink_src_s;

    typedef struct packed {
        logic [7:0] word;
        logic [3:0] idx;
    } dior_out_src_s;

    typedef enum logic [1:0] {DIR_STOP = 2'b00, DIR_CW = 2'b01, DIR_CCW = 2'b11} dior_dir_e;
    typedef enum logic [1:0] {MOT_OFF = 2'b00, MOT_RUN = 2'b01, MOT_BRAKE = 2'b11} dior_mot_e;
    typedef enum logic [1:0] {WM_DIRECT = 2'b00, WM_TWO_1 = 2'b01, WM_TWO_2 = 2'b11} dior_wire_e;

endpackage : dior_pkg

// >>> design/dior_debounce.sv
// Purpose: synchronise and debounce one input pin
// Assumes: filt_steps_i counts filter steps of one step_i pulse each
// Notes:   zero steps passes the synchronised level straight through
`timescale 1ns/1ns
module dior_debounce
    import dior_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic step_i,
    input wire logic pin_i,
    input wire logic [FILT_W-1:0] filt_steps_i,
    output logic level_o
);
    logic s1;
    logic s2;
    logic s3;
    logic [FILT_W-1:0] cnt;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
        end else begin
            s1 <= pin_i;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // a change is seen only once the second and third stage agree
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            level_o <= 1'b0;
            cnt <= '0;
        end else if (s2 != s3 || s3 == level_o) begin
            cnt <= '0;
        end else if (filt_steps_i == '0 || cnt >= filt_steps_i) begin
            level_o <= s3;
            cnt <= '0;
        end else if (step_i) begin
            cnt <= cnt + 1'b1;
        end
    end

endmodule : dior_debounce

// >>> design/dior_out_sel.sv
// Purpose: pick one status bit for a digital output and apply polarity
// Assumes: status words arrive on the system clock
// Notes:   a deselected output stays low whatever its polarity
`timescale 1ns/1ns
module dior_out_sel
    import dior_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire dior_out_src_s src_i,
    input wire logic invert_i,
    input wire logic [15:0] stat_one_i,
    input wire logic [15:0] stat_two_i,
    output logic out_o
);
    function automatic logic pick(input dior_out_src_s s, input logic [15:0] w1,
                                  input logic [15:0] w2);
        logic r;
        r = 1'b0;
        if (s.word == SRC_STAT_ONE) begin
            r = w1[s.idx];
        end else if (s.word == SRC_STAT_TWO) begin
            r = w2[s.idx];
        end
        return r;
    endfunction : pick

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            out_o <= 1'b0;
        end else if (src_i.word == SRC_OUT_OFF) begin
            out_o <= 1'b0;
        end else begin
            out_o <= pick(src_i, stat_one_i, stat_two_i) ^ invert_i;
        end
    end

endmodule : dior_out_sel

// >>> sim/dior_switches.sv
// Purpose: contact model of the switches on the input pins
// Assumes: bits 3:0 plain inputs, bits 5:4 the two-way pins
// Notes:   a level change chatters for chatter_i cycles before settling
`timescale 1ns/1ns
module dior_switches (
    input wire logic clk_i,
    input wire logic [5:0] level_i,
    input wire logic [3:0] chatter_i,
    output logic [5:0] pin_o
);
    logic [5:0] last = 6'h00;
    logic [5:0] moved = 6'h00;
    logic [3:0] cnt = 4'h0;
    always_ff @(posedge clk_i) begin
        last <= level_i;
        if (level_i != last) begin
            moved <= level_i ^ last;
            cnt <= chatter_i;
        end else if (cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
        end
        // only the contacts that moved bounce, so steady pins stay clean
        pin_o <= level_i ^ (cnt[0] ? moved : 6'h00);
    end
endmodule : dior_switches

// >>> sim/dior_checker.sv
// Purpose: port-level assertions for the routing block
// Assumes: one clock, synchronous active-low reset
// Notes:   attached to every dior_top by the bind below
`timescale 1ns/1ns
module dior_checker
    import dior_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [NUM_BIDIR-1:0] bidir_pin_o,
    input wire logic [NUM_BIDIR-1:0] bidir_pin_oe_o,
    input wire logic [NUM_BIDIR-1:0] bidir_is_out_i,
    input wire dior_sink_src_s [NUM_SINKS-1:0] command_sink_selector_i,
    input wire dior_out_src_s [NUM_BIDIR-1:0] out_source_i,
    input wire logic [NUM_BIDIR-1:0] output_polarity_i,
    input wire logic [15:0] status_word_one_i,
    input wire logic [15:0] status_word_two_i,
    input wire logic standstill_i,
    input wire logic [IN_W-1:0] input_state_word_o,
    input wire dior_cmd_s sink_cmd_o,
    input wire logic motor_on_o,
    input wire logic braking_o,
    input wire logic ramp_stop_o,
    input wire logic mop_raise_o,
    input wire logic mop_lower_o,
    input wire logic brake_release_o
);
    default clocking dc @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);
    // --------
    // sequences
    // --------
    sequence s_out_held(int k);
        $past(rst_n_i) && $stable(out_source_i[k]) && $stable(output_polarity_i[k]);
    endsequence
    // wire sinks are idle too, so nothing may restart the motor
    sequence s_brake_done;
        braking_o && standstill_i && !sink_cmd_o.run && !sink_cmd_o.wire1 && !sink_cmd_o.wire2;
    endsequence
    a_reset_quiet: assert property (rst_n_i && !$past(rst_n_i) |->
        sink_cmd_o == '0 && !motor_on_o && bidir_pin_o == '0 && input_state_word_o == '0)
        else $error("outputs not idle after reset");
    a_oe_follow: assert property (bidir_pin_oe_o == bidir_is_out_i)
        else $error("pin enable differs from config");
    a_out_fault_pin: assert property (s_out_held(1) ##0
        (out_source_i[1] == {SRC_STAT_ONE, 4'h3} && !output_polarity_i[1])
        |-> bidir_pin_o[1] == $past(status_word_one_i[3])) else $error("pin 25 not fault");
    a_out_invert: assert property (s_out_held(0) ##0 out_source_i[0].word == SRC_STAT_TWO
        |-> bidir_pin_o[0] == ($past(status_word_two_i[out_source_i[0].idx]) ^ output_polarity_i[0]))
        else $error("output polarity wrong");
    a_out_off_low: assert property (s_out_held(0) ##0 out_source_i[0].word == SRC_OUT_OFF
        |-> !bidir_pin_o[0]) else $error("deselected output high");
    a_run_routes: assert property ($past(rst_n_i) && $stable(command_sink_selector_i[SNK_RUN])
        && command_sink_selector_i[SNK_RUN].word == SRC_INPUT_WORD |-> sink_cmd_o.run ==
        $past(input_state_word_o[command_sink_selector_i[SNK_RUN].idx])) else $error("run route");
    a_sink_idle: assert property ($past(rst_n_i) && $stable(command_sink_selector_i[SNK_COAST])
        && command_sink_selector_i[SNK_COAST].word != SRC_INPUT_WORD |-> !sink_cmd_o.coast)
        else $error("unrouted sink active");
    a_coast_off: assert property (sink_cmd_o.coast |=> !motor_on_o && !braking_o)
        else $error("coast did not switch off");
    a_ramp_brakes: assert property (ramp_stop_o |-> braking_o)
        else $error("ramp stop without braking");
    a_stop_done: assert property (s_brake_done |=> !braking_o)
        else $error("braking past standstill");
    a_brake_prio: assert property (brake_release_o ==
        (sink_cmd_o.brk_rel && !sink_cmd_o.brk_close)) else $error("brake release wrong");
    a_mop_excl: assert property (mop_raise_o == (sink_cmd_o.mop_up && !sink_cmd_o.mop_down)
        && mop_lower_o == (sink_cmd_o.mop_down && !sink_cmd_o.mop_up)) else $error("pot wrong");
endmodule : dior_checker
bind dior_top dior_checker u_checker (.clk_i, .rst_n_i, .bidir_pin_o,
    .bidir_pin_oe_o, .bidir_is_out_i, .command_sink_selector_i, .out_source_i,
    .output_polarity_i, .status_word_one_i, .status_word_two_i, .standstill_i,
    .input_state_word_o, .sink_cmd_o, .motor_on_o, .braking_o, .ramp_stop_o, .mop_raise_o,
    .mop_lower_o, .brake_release_o);

// >>> sim/testbench.sv
// Purpose: self-checking bench for the routing block
// Assumes: filter step shortened to four clocks
// Notes:   expectations come from bench functions, inline expressions and the m2 table
`timescale 1ns/1ns
module testbench;
    import dior_pkg::*;
    localparam logic [7:0] WTAB [4] = '{SRC_OUT_OFF, SRC_STAT_ONE, SRC_STAT_TWO, 8'h2d};
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [5:0] sw_level = 6'h00;
    logic [3:0] chatter = 4'h0;
    logic [5:0] sw_pin;
    logic [NUM_DI-1:0] ext_input_pin_i;
    logic [NUM_BIDIR-1:0] bidir_pin_i, bidir_pin_o, bidir_pin_oe_o;
    logic [NUM_BIDIR-1:0] bidir_is_out_i = 2'h0;
    logic [FILT_W-1:0] input_filter_time_i = 4'h0;
    dior_sink_src_s [NUM_SINKS-1:0] command_sink_selector_i = '0;
    dior_out_src_s [NUM_BIDIR-1:0] out_source_i = '0;
    logic [NUM_BIDIR-1:0] output_polarity_i = 2'h0;
    logic [15:0] status_word_one_i = 16'h0000;
    logic [15:0] status_word_two_i = 16'h0000;
    logic [7:0] preset_macro_sel_i = 8'h00;
    logic quick_comm_i = 1'b0;
    logic standstill_i = 1'b0;
    logic [IN_W-1:0] input_state_word_o;
    dior_cmd_s sink_cmd_o;
    logic motor_on_o, braking_o, dir_ccw_o, setpoint_negate_o, ramp_stop_o, fast_ramp_stop_o;
    logic coast_stop_o, command_set_select_o, mop_raise_o, mop_lower_o, brake_release_o;
    int fail_count = 0;
    int comparisons = 0;
    int cycles = 0;
    int pick;
    logic [31:0] rnd = 32'h000147ff;
    logic [5:0] lv;
    logic [11:0] ecmd;
    logic seen;
    dior_out_src_s os [2];
    logic [1:0] pv;
    // per step: standstill, ccw, cw, motor checked, motor, ccw direction
    logic [5:0] m2 [6] = '{6'b101110, 6'b011110, 6'b010000, 6'b100100, 6'b110111, 6'b011111};
    initial begin
        forever #10 clk_i = ~clk_i;
    end
    dior_switches u_sw (.clk_i, .level_i(sw_level), .chatter_i(chatter), .pin_o(sw_pin));
    assign ext_input_pin_i = sw_pin[3:0];
    // a pin the block drives reads back its own level
    assign bidir_pin_i = (bidir_pin_oe_o & bidir_pin_o) | (~bidir_pin_oe_o & sw_pin[5:4]);
    dior_top #(.FILT_TICK(4)) dut (.clk_i, .rst_n_i, .ext_input_pin_i, .bidir_pin_i,
        .bidir_pin_o, .bidir_pin_oe_o, .bidir_is_out_i, .input_filter_time_i,
        .command_sink_selector_i, .out_source_i, .output_polarity_i, .status_word_one_i,
        .status_word_two_i, .preset_macro_sel_i, .quick_comm_i, .standstill_i,
        .input_state_word_o, .sink_cmd_o, .motor_on_o, .braking_o, .dir_ccw_o,
        .setpoint_negate_o, .ramp_stop_o, .fast_ramp_stop_o, .coast_stop_o,
        .command_set_select_o, .mop_raise_o, .mop_lower_o, .brake_release_o);
    function automatic logic [31:0] nxt(logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : nxt
    function automatic logic [4:0] idx_of(int c);
        return (c < 4) ? 5'(c) : BIDIR_BIT0 + 5'(c - 4);
    endfunction : idx_of
    function automatic logic [31:0] ist_exp(logic [5:0] l, logic [1:0] o);
        return {6'h00, l[5:4] & ~o, 20'h00000, l[3:0]};
    endfunction : ist_exp
    function automatic logic out_exp(dior_out_src_s s, logic inv, logic [15:0] a, logic [15:0] b);
        return (s.word == SRC_STAT_ONE) ? a[s.idx] ^ inv :
            (s.word == SRC_STAT_TWO) ? b[s.idx] ^ inv : 1'b0;
    endfunction : out_exp
    task automatic chk(string what, logic [31:0] seen_v, logic [31:0] exp_v);
        comparisons++;
        if (seen_v !== exp_v) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp_v, seen_v);
        end
    endtask : chk
    task automatic cyc(int n);
        repeat (n) @(posedge clk_i);
    endtask : cyc
    task automatic look(int n);
        cyc(n);
        #1;
    endtask : look
    task automatic set_macro(logic [7:0] m);
        cyc(1);
        command_sink_selector_i <= '0;
        quick_comm_i <= 1'b1;
        preset_macro_sel_i <= m;
        cyc(2);
        quick_comm_i <= 1'b0;
    endtask : set_macro
    task automatic conclude();
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : conclude
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            fail_count++;
            conclude();
        end
    end
    initial begin
        cyc(2);
        rst_n_i <= 1'b1;
        look(1);
        chk("sinks", sink_cmd_o, 32'h0);
        chk("pins", bidir_pin_o, 32'h0);
        for (int n = 0; n < 8; n++) begin
            cyc(1);
            rnd = nxt(rnd);
            lv = rnd[5:0];
            sw_level <= lv;
            for (int k = 0; k < NUM_SINKS; k++) begin
                rnd = nxt(rnd);
                pick = rnd[7:0] % 6;
                command_sink_selector_i[k] <= {SRC_INPUT_WORD, idx_of(pick)};
                ecmd[k] = lv[pick];
            end
            look(12);
            chk("cmd", sink_cmd_o, ecmd);
            chk("state", input_state_word_o, ist_exp(lv, 2'b00));
            chk("cds", command_set_select_o, ecmd[SNK_CDS0]);
            chk("raise", mop_raise_o, ecmd[SNK_MOP_UP] & ~ecmd[SNK_MOP_DOWN]);
            chk("release", brake_release_o, ecmd[SNK_BRK_REL] & ~ecmd[SNK_BRK_CLOSE]);
        end
        cyc(1);
        command_sink_selector_i <= '0;
        command_sink_selector_i[SNK_RUN] <= {SRC_INPUT_WORD, 5'h00};
        input_filter_time_i <= 4'h2;
        sw_level <= 6'h00;
        cyc(40);
        sw_level <= 6'h01;
        cyc(4);
        sw_level <= 6'h00;
        seen = 1'b0;
        repeat (40) begin
            look(1);
            seen |= sink_cmd_o.run;
        end
        chk("glitch", seen, 1'b0);
        cyc(1);
        chatter <= 4'h7;
        sw_level <= 6'h01;
        look(45);
        chk("debounced", sink_cmd_o.run, 1'b1);
        cyc(1);
        input_filter_time_i <= 4'h0;
        chatter <= 4'h0;
        bidir_is_out_i <= 2'b11;
        sw_level <= 6'h3f;
        for (int n = 0; n < 8; n++) begin
            cyc(1);
            rnd = nxt(rnd);
            status_word_one_i <= rnd[15:0] | ((n == 0) ? 16'h0008 : 16'h0000);
            status_word_two_i <= rnd[31:16];
            rnd = nxt(rnd);
            os[0] = {WTAB[rnd[1:0]], rnd[5:2]};
            os[1] = (n == 0) ? {SRC_STAT_ONE, 4'h3} : {WTAB[rnd[9:8]], rnd[13:10]};
            pv = (n == 0) ? 2'b00 : rnd[17:16];
            out_source_i <= {os[1], os[0]};
            output_polarity_i <= pv;
            look(5);
            for (int k = 0; k < 2; k++) begin
                chk("out", bidir_pin_o[k],
                    out_exp(os[k], pv[k], status_word_one_i, status_word_two_i));
            end
            chk("oe", bidir_pin_oe_o, 2'b11);
            chk("state", input_state_word_o, ist_exp(6'h3f, 2'b11));
        end
        bidir_is_out_i <= 2'b00;
        set_macro(MACRO_TWO_WIRE_1);
        standstill_i <= 1'b1;
        for (int n = 0; n < 4; n++) begin
            cyc(1);
            sw_level <= 6'(n);
            look(14);
            chk("motor", motor_on_o, n[0]);
            chk("dir", dir_ccw_o | ~n[0], n[1] | ~n[0]);
            chk("negate", setpoint_negate_o, n[1]);
        end
        cyc(1);
        standstill_i <= 1'b0;
        sw_level <= 6'h00;
        look(10);
        chk("ramp", {braking_o, ramp_stop_o}, 2'b11);
        cyc(1);
        standstill_i <= 1'b1;
        look(4);
        chk("off", {braking_o, motor_on_o}, 2'b00);
        cyc(1);
        command_sink_selector_i[SNK_COAST] <= {SRC_INPUT_WORD, 5'h02};
        sw_level <= 6'h01;
        cyc(14);
        standstill_i <= 1'b0;
        sw_level <= 6'h05;
        look(10);
        chk("coast", {motor_on_o, braking_o, coast_stop_o}, 3'b001);
        set_macro(MACRO_TWO_WIRE_2);
        sw_level <= 6'h00;
        standstill_i <= 1'b1;
        cyc(14);
        for (int n = 0; n < 6; n++) begin
            standstill_i <= m2[n][5];
            sw_level <= {4'h0, m2[n][4], m2[n][3]};
            look(14);
            if (m2[n][2]) begin
                chk("motor2", motor_on_o, m2[n][1]);
            end
            if (!m2[n][2] || m2[n][1]) begin
                chk("dir2", dir_ccw_o, m2[n][0]);
            end
            cyc(1);
        end
        sw_level <= 6'h00;
        standstill_i <= 1'b1;
        cyc(14);
        command_sink_selector_i[SNK_WIRE1] <= {SRC_INPUT_WORD, 5'h03};
        command_sink_selector_i[SNK_WIRE2] <= {SRC_INPUT_WORD, 5'h02};
        sw_level <= 6'h04;
        look(14);
        chk("wire", {motor_on_o, dir_ccw_o}, 2'b11);
        conclude();
    end
endmodule : testbench
